// ### design/tofhc_pkg.sv
// Purpose: Constants and types for the flight hit capture configuration block
// Assumes: APB slave, 40 MHz clock, crystal tick 32.768 kHz derived by divider
// Notes: Register index times four gives the byte address
package tofhc_pkg;
	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [7:0] IDX_EDGE_CFG = 8'h39;
	localparam logic [7:0] IDX_HIT12_CFG = 8'h3A;
	localparam logic [7:0] IDX_HIT34_CFG = 8'h3B;
	localparam logic [7:0] IDX_HIT56_CFG = 8'h3C;
	localparam logic [7:0] IDX_BIAS_CFG = 8'h38;
	localparam logic [7:0] IDX_CTRL = 8'h50;
	localparam logic [7:0] IDX_STATUS = 8'h51;
	localparam logic [7:0] IDX_MASK = 8'h52;
	localparam logic [7:0] IDX_RESULT = 8'h53;
	localparam logic [7:0] IDX_WAVES_A = 8'h54;
	localparam logic [7:0] IDX_WAVES_B = 8'h55;
	// ****************************************
	// Reset values and timeout result
	// ****************************************
	localparam logic [15:0] RST_EDGE_CFG = 16'h0000;
	localparam logic [15:0] RST_HIT_CFG = 16'h0000;
	localparam logic [15:0] RST_BIAS_CFG = 16'h0000;
	localparam logic [15:0] RESULT_INVALID = 16'hFFFF;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int HITS_LSB = 13;
	localparam int EDGE_LSB = 7;
	localparam int CYC_LSB = 4;
	localparam int TMO_LSB = 0;
	localparam int WAVE_HI_LSB = 8;
	localparam int WAVE_LO_LSB = 0;
	localparam int ST_TMO = 0;
	localparam int ST_DONE = 1;
	localparam int CTL_START = 0;
	localparam int CTL_PAIRED = 1;
	localparam int CTL_ECHO = 2;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 40000000;
	localparam int XTAL_HZ = 32768;
	localparam int XTAL_DIV = CLK_HZ / XTAL_HZ;
	localparam int TMO_BASE_US = 128;
	localparam int TMO_BASE_CYC = TMO_BASE_US * (CLK_HZ / 1000000);
	localparam logic [9:0] BIAS_CYC [4] = '{10'h002, 10'h004, 10'h008, 10'h010};
	localparam logic [9:0] REPEAT_CYC [8] = '{10'h000, 10'h004, 10'h008, 10'h010,
		10'h018, 10'h020, 10'h222, 10'h28F};
	localparam logic [5:0] MIN_EDGE = 6'h02;
	localparam logic [5:0] MIN_HIT [6] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08};
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_BIAS = 3'b001,
		S_RUN = 3'b010,
		S_GAP = 3'b011,
		S_DONE = 3'b100
	} tofhc_state_e;
	typedef struct packed {
		logic [2:0] hits;
		logic [5:0] edge_wave;
		logic [2:0] repeat_sel;
		logic [2:0] expiry_sel;
	} tofhc_cfg_s;
endpackage : tofhc_pkg

// ### design/tofhc_wave_clamp.sv
// Purpose: Raise a wave code to the earliest measurable wave
// Assumes: Codes are six bits
// Notes: One instance per hit and the early edge
`timescale 1ns/1ps
module tofhc_wave_clamp
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Wave code in and floor
	input wire logic [5:0] code,
	input wire logic [5:0] floor_wave,
	// Effective wave
	output logic [5:0] wave
);
	logic [5:0] wave_reg;
	logic [5:0] wave_next;

	// Codes below the floor measure the floor wave
	always_comb
	begin
		wave_next = (code < floor_wave) ? floor_wave : code;
	end

	// Register so the top sees a flopped value
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wave_reg <= 6'h00;
		else
			wave_reg <= wave_next;
	end

	assign wave = wave_reg;
endmodule : tofhc_wave_clamp

// ### design/tofhc_top.sv
// Purpose: Flight hit capture configuration registers and measurement sequencer
// Assumes: APB master, single 40 MHz clock, echo input marks received flight end
// Notes: Zero wait state APB; unmapped reads give zero with no error
`timescale 1ns/1ps
module tofhc_top
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Flight front end
	input wire logic ECHO_SEEN,
	input wire logic [15:0] RESULT_IN,
	output logic REF_CLK_ON,
	output logic BIAS_SETTLING,
	output logic FLIGHT_ACTIVE,
	output logic DOWNSTREAM_RUN,
	output logic [2:0] HIT_TOTAL,
	// Interrupt
	output logic IRQ
);
	// ****************************************
	// Register file
	// ****************************************
	logic [15:0] edge_cfg_reg, edge_cfg_next;
	logic [15:0] hit12_reg, hit12_next;
	logic [15:0] hit34_reg, hit34_next;
	logic [15:0] hit56_reg, hit56_next;
	logic [1:0] bias_reg, bias_next;
	logic [1:0] status_reg, status_next;
	logic [1:0] mask_reg, mask_next;
	logic [15:0] result_reg, result_next;
	logic [31:0] prdata_reg, prdata_next;
	logic irq_reg, irq_next;
	logic start_pulse, paired_pulse;
	logic wr_cyc, rd_cyc;
	logic [9:0] index;
	logic tmo_evt, done_evt, valid_evt;
	logic [5:0] eff_wave [7];
	logic [5:0] raw_wave [7];
	logic [5:0] floor_wave [7];

	// Word index from byte address
	assign index = PADDR[11:2];
	assign wr_cyc = PSEL && PENABLE && PWRITE;
	assign rd_cyc = PSEL && !PENABLE && !PWRITE;

	// Next state of software visible registers
	always_comb
	begin
		edge_cfg_next = edge_cfg_reg;
		hit12_next = hit12_reg;
		hit34_next = hit34_reg;
		hit56_next = hit56_reg;
		bias_next = bias_reg;
		mask_next = mask_reg;
		start_pulse = 1'b0;
		paired_pulse = 1'b0;
		status_next = status_reg;
		result_next = result_reg;
		if (wr_cyc)
		begin
			case (index)
				{2'b00, tofhc_pkg::IDX_EDGE_CFG}: edge_cfg_next = PWDATA[15:0] & 16'hFFF7;
				{2'b00, tofhc_pkg::IDX_HIT12_CFG}: hit12_next = PWDATA[15:0] & 16'h3F3F;
				{2'b00, tofhc_pkg::IDX_HIT34_CFG}: hit34_next = PWDATA[15:0] & 16'h3F3F;
				{2'b00, tofhc_pkg::IDX_HIT56_CFG}: hit56_next = PWDATA[15:0] & 16'h3F3F;
				{2'b00, tofhc_pkg::IDX_BIAS_CFG}: bias_next = PWDATA[1:0];
				{2'b00, tofhc_pkg::IDX_MASK}: mask_next = PWDATA[1:0];
				{2'b00, tofhc_pkg::IDX_STATUS}: status_next = status_reg & ~PWDATA[1:0];
				{2'b00, tofhc_pkg::IDX_CTRL}:
				begin
					start_pulse = PWDATA[tofhc_pkg::CTL_START];
					paired_pulse = PWDATA[tofhc_pkg::CTL_PAIRED];
				end
				default: ;
			endcase
		end
		// Hardware set wins over a write-one clear in the same cycle
		if (tmo_evt)
			status_next[tofhc_pkg::ST_TMO] = 1'b1;
		if (done_evt)
			status_next[tofhc_pkg::ST_DONE] = 1'b1;
		if (tmo_evt)
			result_next = tofhc_pkg::RESULT_INVALID;
		else if (valid_evt)
			result_next = RESULT_IN;
		irq_next = |(status_next & mask_next);
	end

	// Read mux registered in setup so data stands in access phase
	always_comb
	begin
		prdata_next = prdata_reg;
		if (rd_cyc)
		begin
			case (index)
				{2'b00, tofhc_pkg::IDX_EDGE_CFG}: prdata_next = {16'h0000, edge_cfg_reg};
				{2'b00, tofhc_pkg::IDX_HIT12_CFG}: prdata_next = {16'h0000, hit12_reg};
				{2'b00, tofhc_pkg::IDX_HIT34_CFG}: prdata_next = {16'h0000, hit34_reg};
				{2'b00, tofhc_pkg::IDX_HIT56_CFG}: prdata_next = {16'h0000, hit56_reg};
				{2'b00, tofhc_pkg::IDX_BIAS_CFG}: prdata_next = {30'h00000000, bias_reg};
				{2'b00, tofhc_pkg::IDX_STATUS}: prdata_next = {30'h00000000, status_reg};
				{2'b00, tofhc_pkg::IDX_MASK}: prdata_next = {30'h00000000, mask_reg};
				{2'b00, tofhc_pkg::IDX_RESULT}: prdata_next = {16'h0000, result_reg};
				{2'b00, tofhc_pkg::IDX_WAVES_A}:
					prdata_next = {8'h00, eff_wave[3], eff_wave[2], eff_wave[1], eff_wave[0]};
				{2'b00, tofhc_pkg::IDX_WAVES_B}:
					prdata_next = {14'h0000, eff_wave[6], eff_wave[5], eff_wave[4]};
				default: prdata_next = 32'h00000000;
			endcase
		end
	end

	// Register bank storage
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			edge_cfg_reg <= tofhc_pkg::RST_EDGE_CFG;
			hit12_reg <= tofhc_pkg::RST_HIT_CFG;
			hit34_reg <= tofhc_pkg::RST_HIT_CFG;
			hit56_reg <= tofhc_pkg::RST_HIT_CFG;
			bias_reg <= tofhc_pkg::RST_BIAS_CFG[1:0];
			status_reg <= 2'b00;
			mask_reg <= 2'b00;
			result_reg <= 16'h0000;
			prdata_reg <= 32'h00000000;
			irq_reg <= 1'b0;
		end
		else
		begin
			edge_cfg_reg <= edge_cfg_next;
			hit12_reg <= hit12_next;
			hit34_reg <= hit34_next;
			hit56_reg <= hit56_next;
			bias_reg <= bias_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			result_reg <= result_next;
			prdata_reg <= prdata_next;
			irq_reg <= irq_next;
		end
	end

	// ****************************************
	// Wave selection clamps
	// ****************************************
	// Host keeps each code above the previous; hardware only floors them
	assign raw_wave[0] = edge_cfg_reg[tofhc_pkg::EDGE_LSB +: 6];
	assign raw_wave[1] = hit12_reg[tofhc_pkg::WAVE_HI_LSB +: 6];
	assign raw_wave[2] = hit12_reg[tofhc_pkg::WAVE_LO_LSB +: 6];
	assign raw_wave[3] = hit34_reg[tofhc_pkg::WAVE_HI_LSB +: 6];
	assign raw_wave[4] = hit34_reg[tofhc_pkg::WAVE_LO_LSB +: 6];
	assign raw_wave[5] = hit56_reg[tofhc_pkg::WAVE_HI_LSB +: 6];
	assign raw_wave[6] = hit56_reg[tofhc_pkg::WAVE_LO_LSB +: 6];
	assign floor_wave[0] = tofhc_pkg::MIN_EDGE;
	assign floor_wave[1] = tofhc_pkg::MIN_HIT[0];
	assign floor_wave[2] = tofhc_pkg::MIN_HIT[1];
	assign floor_wave[3] = tofhc_pkg::MIN_HIT[2];
	assign floor_wave[4] = tofhc_pkg::MIN_HIT[3];
	assign floor_wave[5] = tofhc_pkg::MIN_HIT[4];
	assign floor_wave[6] = tofhc_pkg::MIN_HIT[5];

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_clamp
			tofhc_wave_clamp u_clamp
			(
				.clk(CLK),
				.rst_n(RST_N),
				.code(raw_wave[gi]),
				.floor_wave(floor_wave[gi]),
				.wave(eff_wave[gi])
			);
		end
	endgenerate

	// ****************************************
	// Crystal tick and sequencer
	// ****************************************
	tofhc_pkg::tofhc_cfg_s cfg;
	tofhc_pkg::tofhc_state_e state_reg, state_next;
	logic [10:0] div_reg, div_next;
	logic [9:0] xcnt_reg, xcnt_next;
	// Twenty bits: the longest expiry code needs 655360 cycles
	logic [19:0] tcnt_reg, tcnt_next;
	logic paired_reg, paired_next;
	logic down_reg, down_next;
	logic refon_reg, refon_next;
	logic [2:0] hits_reg, hits_next;
	logic xtick;
	logic [19:0] tmo_limit;

	assign cfg = {edge_cfg_reg[15:13], edge_cfg_reg[12:7], edge_cfg_reg[6:4], edge_cfg_reg[2:0]};
	assign xtick = (div_reg == 11'(tofhc_pkg::XTAL_DIV - 1));
	assign tmo_limit = 20'(tofhc_pkg::TMO_BASE_CYC) << cfg.expiry_sel;

	// Sequencer next state
	always_comb
	begin
		state_next = state_reg;
		div_next = xtick ? 11'h000 : div_reg + 11'h001;
		xcnt_next = xcnt_reg;
		tcnt_next = tcnt_reg;
		paired_next = paired_reg;
		down_next = down_reg;
		refon_next = refon_reg;
		tmo_evt = 1'b0;
		done_evt = 1'b0;
		valid_evt = 1'b0;
		hits_next = (cfg.hits > 3'h4) ? 3'h6 : cfg.hits + 3'h1;
		case (state_reg)
			tofhc_pkg::S_IDLE:
			begin
				if (start_pulse || paired_pulse)
				begin
					state_next = tofhc_pkg::S_BIAS;
					paired_next = paired_pulse;
					down_next = 1'b0;
					refon_next = 1'b1;
					xcnt_next = 10'h000;
				end
			end
			tofhc_pkg::S_BIAS:
			begin
				if (xtick)
					xcnt_next = xcnt_reg + 10'h001;
				if (xtick && (xcnt_reg + 10'h001 >= tofhc_pkg::BIAS_CYC[bias_reg]))
				begin
					state_next = tofhc_pkg::S_RUN;
					tcnt_next = 20'h00000;
				end
			end
			tofhc_pkg::S_RUN:
			begin
				tcnt_next = tcnt_reg + 20'h00001;
				if (xtick)
					xcnt_next = xcnt_reg + 10'h001;
				if (tcnt_reg + 20'h00001 >= tmo_limit)
				begin
					tmo_evt = 1'b1;
					state_next = tofhc_pkg::S_DONE;
				end
				else if (ECHO_SEEN)
				begin
					valid_evt = 1'b1;
					if (paired_reg && !down_reg)
					begin
						state_next = tofhc_pkg::S_GAP;
						refon_next = (cfg.repeat_sel < 3'h6);
					end
					else
						state_next = tofhc_pkg::S_DONE;
				end
			end
			tofhc_pkg::S_GAP:
			begin
				if (xtick)
					xcnt_next = xcnt_reg + 10'h001;
				// Overrun of the interval launches at once, as code zero
				if (xcnt_reg >= tofhc_pkg::REPEAT_CYC[cfg.repeat_sel])
				begin
					state_next = tofhc_pkg::S_BIAS;
					down_next = 1'b1;
					refon_next = 1'b1;
					xcnt_next = 10'h000;
				end
			end
			tofhc_pkg::S_DONE:
			begin
				done_evt = 1'b1;
				refon_next = 1'b0;
				down_next = 1'b0; // Downstream flag only from the second bias of the pair to done
				state_next = tofhc_pkg::S_IDLE;
			end
			default: state_next = tofhc_pkg::S_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			state_reg <= tofhc_pkg::S_IDLE;
			div_reg <= 11'h000;
			xcnt_reg <= 10'h000;
			tcnt_reg <= 20'h00000;
			paired_reg <= 1'b0;
			down_reg <= 1'b0;
			refon_reg <= 1'b0;
			hits_reg <= 3'h1;
		end
		else
		begin
			state_reg <= state_next;
			div_reg <= div_next;
			xcnt_reg <= xcnt_next;
			tcnt_reg <= tcnt_next;
			paired_reg <= paired_next;
			down_reg <= down_next;
			refon_reg <= refon_next;
			hits_reg <= hits_next;
		end
	end

	// Outputs come from flops, PSLVERR tied low; zero wait state slave
	logic ready_reg;
	logic bias_o_reg, run_o_reg;
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			ready_reg <= 1'b0;
			bias_o_reg <= 1'b0;
			run_o_reg <= 1'b0;
		end
		else
		begin
			ready_reg <= PSEL && !PENABLE;
			bias_o_reg <= (state_next == tofhc_pkg::S_BIAS);
			run_o_reg <= (state_next == tofhc_pkg::S_RUN);
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = ready_reg;
	assign PSLVERR = 1'b0;
	assign REF_CLK_ON = refon_reg;
	assign BIAS_SETTLING = bias_o_reg;
	assign FLIGHT_ACTIVE = run_o_reg;
	assign DOWNSTREAM_RUN = down_reg;
	assign HIT_TOTAL = hits_reg;
	assign IRQ = irq_reg;
endmodule : tofhc_top

// ### bench/tofhc_chk.sv
// Purpose: Port checks on the hit capture block
// Assumes: One clock, synchronous active low reset
// Notes: Counters bound the long phases
`timescale 1ns/1ps
module tofhc_chk
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Flight front end
	input wire logic ECHO_SEEN,
	input wire logic [15:0] RESULT_IN,
	input wire logic REF_CLK_ON,
	input wire logic BIAS_SETTLING,
	input wire logic FLIGHT_ACTIVE,
	input wire logic DOWNSTREAM_RUN,
	input wire logic [2:0] HIT_TOTAL,
	// Interrupt
	input wire logic IRQ
);
	// ********
	// Phase counters
	// ********
	localparam int BIAS_MAX = 17 * tofhc_pkg::XTAL_DIV;
	localparam int RUN_MAX = (tofhc_pkg::TMO_BASE_CYC << 7) + 16;
	logic [15:0] bias_cnt_reg, bias_cnt_next;
	logic [19:0] run_cnt_reg, run_cnt_next;
	// Cleared outside the phase, so one long phase cannot hide
	always_comb
	begin
		bias_cnt_next = (RST_N && BIAS_SETTLING) ? bias_cnt_reg + 16'h0001 : 16'h0000;
		run_cnt_next = (RST_N && FLIGHT_ACTIVE) ? run_cnt_reg + 20'h00001 : 20'h00000;
	end
	always_ff @(posedge CLK)
	begin
		bias_cnt_reg <= bias_cnt_next;
		run_cnt_reg <= run_cnt_next;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// ********
	// Assertions
	// ********
	a_bias_bound: assert property (bias_cnt_reg <= BIAS_MAX)
		else $error("bias phase too long");
	a_bias_to_run: assert property ($fell(BIAS_SETTLING) |-> ##[0:2] FLIGHT_ACTIVE)
		else $error("no run after bias");
	a_run_bound: assert property (run_cnt_reg <= RUN_MAX)
		else $error("run outlived expiry");
	a_ref_in_run: assert property (FLIGHT_ACTIVE |-> REF_CLK_ON)
		else $error("reference off in run");
	a_echo_ends: assert property (FLIGHT_ACTIVE && ECHO_SEEN |-> ##[1:3] !FLIGHT_ACTIVE)
		else $error("echo did not end run");
	a_hit_range: assert property (HIT_TOTAL >= 3'h1 && HIT_TOTAL <= 3'h6)
		else $error("hit total out of range");
	a_wave_low: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 12'h150 |=>
		PRDATA[5:0] >= 6'h02 && PRDATA[11:6] >= 6'h03 && PRDATA[17:12] >= 6'h04)
		else $error("early wave below floor");
	a_wave_high: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 12'h154 |=>
		PRDATA[11:6] >= 6'h07 && PRDATA[17:12] >= 6'h08)
		else $error("late wave below floor");
	a_ready_pulse: assert property (PREADY |=> !PREADY && !PSLVERR)
		else $error("ready held or error");
endmodule : tofhc_chk

// ### bench/tofhc_front_model.sv
// Purpose: Transducer side, echo after a set delay in the run phase
// Assumes: Echo held until the run phase ends
// Notes: A delay of zero never echoes, which forces expiry
`timescale 1ns/1ps
module tofhc_front_model
(
	// Clock and run phase
	input wire logic clk,
	input wire logic active,
	// Delay and value
	input wire logic [15:0] dly,
	input wire logic [15:0] val,
	// Echo and result lines
	output logic echo,
	output logic [15:0] res
);
	logic [15:0] cnt = 16'h0000;
	logic hit;
	assign hit = active && dly != 16'h0000 && (echo || cnt == dly);
	initial
	begin
		echo = 1'b0;
		res = 16'h0000;
	end
	// Result toggles outside the echo so stale data never matches
	always @(posedge clk)
	begin
		cnt <= active ? cnt + 16'h0001 : 16'h0000;
		echo <= hit;
		res <= hit ? val : ~res;
	end
endmodule : tofhc_front_model

// ### bench/tb.sv
// Purpose: Self-checking bench for the hit capture block
// Assumes: APB master at 40 MHz, transducer model on the echo
// Notes: Long interval code 6 is watched at gap start only; code 7 is not driven
`timescale 1ns/1ps
module tb;
	localparam int DIV = tofhc_pkg::XTAL_DIV;
	localparam logic [7:0] EDGE = tofhc_pkg::IDX_EDGE_CFG;
	localparam logic [7:0] CTRL = tofhc_pkg::IDX_CTRL;
	localparam logic [7:0] STAT = tofhc_pkg::IDX_STATUS;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [15:0] echo_dly = 16'h0000;
	logic [15:0] echo_val = 16'h0000;
	logic [31:0] prdata, rd;
	logic [15:0] result_in;
	logic [2:0] hit_total;
	logic pready, pslverr, echo_seen, ref_on, bias, active, down, irq;
	int err_total = 0;
	int check_count = 0;
	int n;
	// ********
	// Clock, design and model
	// ********
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	tofhc_top dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ECHO_SEEN(echo_seen), .RESULT_IN(result_in), .REF_CLK_ON(ref_on), .BIAS_SETTLING(bias),
		.FLIGHT_ACTIVE(active), .DOWNSTREAM_RUN(down), .HIT_TOTAL(hit_total), .IRQ(irq));
	tofhc_front_model model_u (.clk(clk), .active(active), .dly(echo_dly), .val(echo_val),
		.echo(echo_seen), .res(result_in));
	// ********
	// Shared tasks
	// ********
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task hang;
		err_total++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
		end_sim();
	endtask : hang
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task rng(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : rng
	// Request held until ready is sampled high
	task apb(input logic wr_en, input logic [7:0] idx, input logic [31:0] wd);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; pready !== 1'b1; k++)
		begin
			@(posedge clk);
			if (k > 20)
				hang();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] idx, input logic [31:0] wd);
		apb(1'b1, idx, wd);
	endtask : wr
	task rc(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		chk(rd, exp);
	endtask : rc
	// Bounded wait on run (0) or bias (1) phase level
	task wait_sig(input int w, input logic v, input int lim);
		n = 0;
		while ((w == 0 ? active : bias) !== v)
		begin
			@(posedge clk);
			n++;
			if (n > lim)
				hang();
		end
	endtask : wait_sig
	task do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask : do_reset
	// ********
	// Scenarios
	// ********
	task t_fields;
		chk({27'h0, hit_total, ref_on, irq}, 32'h00000004);
		for (int i = 0; i < 4; i++)
			rc(EDGE + 8'(i), 32'h00000000);
		wr(EDGE, 32'h0000FFFF);
		rc(EDGE, 32'h0000FFF7);
		wr(tofhc_pkg::IDX_HIT34_CFG, 32'h0000FFFF);
		rc(tofhc_pkg::IDX_HIT34_CFG, 32'h00003F3F);
		wr(8'hFF, 32'h00001234);
		rc(8'hFF, 32'h00000000);
		for (int c = 0; c < 8; c++)
		begin
			wr(EDGE, 32'(c) << 13);
			repeat (3) @(posedge clk);
			chk({29'h0, hit_total}, (c < 5) ? 32'(c + 1) : 32'h00000006);
		end
		$display("fields done");
	endtask : t_fields
	task t_clamp;
		for (int i = 0; i < 4; i++)
			wr(EDGE + 8'(i), 32'h00000000);
		rc(tofhc_pkg::IDX_WAVES_A, {8'h00, 6'h05, 6'h04, 6'h03, 6'h02});
		rc(tofhc_pkg::IDX_WAVES_B, {14'h0000, 6'h08, 6'h07, 6'h06});
		wr(EDGE, 32'h00000480);
		wr(tofhc_pkg::IDX_HIT12_CFG, 32'h00000A0B);
		wr(tofhc_pkg::IDX_HIT34_CFG, 32'h00000C0D);
		wr(tofhc_pkg::IDX_HIT56_CFG, 32'h00000E0F);
		rc(tofhc_pkg::IDX_WAVES_A, {8'h00, 6'h0C, 6'h0B, 6'h0A, 6'h09});
		rc(tofhc_pkg::IDX_WAVES_B, {14'h0000, 6'h0F, 6'h0E, 6'h0D});
		$display("clamp done");
	endtask : t_clamp
	task t_bias;
		wr(EDGE, 32'h00000001);
		for (int c = 0; c < 4; c++)
		begin
			wr(tofhc_pkg::IDX_BIAS_CFG, 32'(c));
			echo_dly <= 16'h0028;
			echo_val <= 16'h1230 + 16'(c);
			wr(CTRL, 32'h00000001);
			wait_sig(1, 1'b1, 50);
			wait_sig(1, 1'b0, 20 * DIV);
			rng(n, (2 << c) * DIV - DIV, (2 << c) * DIV + 2);
			wait_sig(0, 1'b1, 10);
			wait_sig(0, 1'b0, 200);
			rc(tofhc_pkg::IDX_RESULT, {16'h0000, echo_val});
			rc(STAT, 32'h00000002);
			wr(STAT, 32'h00000003);
		end
		$display("bias done");
	endtask : t_bias
	task t_expiry;
		wr(tofhc_pkg::IDX_BIAS_CFG, 32'h00000000);
		wr(EDGE, 32'h00000000);
		echo_dly <= 16'h0000;
		wr(tofhc_pkg::IDX_MASK, 32'h00000001);
		wr(CTRL, 32'h00000001);
		wait_sig(0, 1'b1, 4 * DIV);
		wait_sig(0, 1'b0, 8000);
		rng(n, tofhc_pkg::TMO_BASE_CYC - 2, tofhc_pkg::TMO_BASE_CYC + 2);
		apb(1'b0, STAT, 32'h00000000);
		chk(rd & 32'h00000001, 32'h00000001);
		chk({31'h0, irq}, 32'h00000001);
		rc(tofhc_pkg::IDX_RESULT, 32'h0000FFFF);
		wr(tofhc_pkg::IDX_MASK, 32'h00000000);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		wr(tofhc_pkg::IDX_MASK, 32'h00000001);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h00000001);
		wr(STAT, 32'h00000003);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h00000000);
		rc(STAT, 32'h00000000);
		$display("expiry done");
	endtask : t_expiry
	task t_paired;
		wr(EDGE, 32'h00000011);
		echo_dly <= 16'h0064;
		wr(CTRL, 32'h00000002);
		wait_sig(0, 1'b1, 4 * DIV);
		wait_sig(0, 1'b0, 400);
		repeat (50) @(posedge clk);
		chk({31'h0, ref_on}, 32'h00000001);
		wait_sig(0, 1'b1, 6 * DIV);
		rng(n + 50, 3 * DIV, 5 * DIV);
		chk({31'h0, down}, 32'h00000001);
		wait_sig(0, 1'b0, 400);
		repeat (3) @(posedge clk);
		chk({31'h0, down}, 32'h00000000);
		// Flight longer than the interval
		wr(EDGE, 32'h00000012);
		echo_dly <= 16'h1770;
		wr(CTRL, 32'h00000002);
		wait_sig(0, 1'b1, 4 * DIV);
		wait_sig(0, 1'b0, 7000);
		wait_sig(0, 1'b1, 4 * DIV);
		rng(n, 0, 3 * DIV - 1);
		wait_sig(0, 1'b0, 7000);
		// Long interval stops the reference, then reset mid-gap
		wr(EDGE, 32'h00000061);
		echo_dly <= 16'h0064;
		wr(CTRL, 32'h00000002);
		wait_sig(0, 1'b1, 4 * DIV);
		wait_sig(0, 1'b0, 400);
		repeat (5) @(posedge clk);
		chk({31'h0, ref_on}, 32'h00000000);
		do_reset();
		chk({30'h0, ref_on, down}, 32'h00000000);
		rc(EDGE, 32'h00000000);
		$display("paired done");
	endtask : t_paired
	initial
	begin
		do_reset();
		t_fields();
		t_clamp();
		t_bias();
		t_expiry();
		t_paired();
		end_sim();
	end
endmodule : tb
bind tofhc_top tofhc_chk chk_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .ECHO_SEEN(ECHO_SEEN), .RESULT_IN(RESULT_IN), .REF_CLK_ON(REF_CLK_ON),
	.BIAS_SETTLING(BIAS_SETTLING), .FLIGHT_ACTIVE(FLIGHT_ACTIVE),
	.DOWNSTREAM_RUN(DOWNSTREAM_RUN), .HIT_TOTAL(HIT_TOTAL), .IRQ(IRQ));
